// File: logic/iows_pkg.sv
// Constants for the peripheral port wait-state sequencer
package iows_pkg;
  // Port strobe styles
  typedef enum logic [1:0] {
    IOWS_STYLE_SPLIT = 2'h0,  // Separate read and write strobes
    IOWS_STYLE_DIR = 2'h1,    // Data strobe plus direction line
    IOWS_STYLE_CARD = 2'h2    // 16-bit card style, select pair per lane
  } iows_style_e;
  // Peripheral width and alignment of the attached device
  typedef enum logic [1:0] {
    IOWS_ATT_W16_WORD = 2'h0,
    IOWS_ATT_W16_HALF = 2'h1,
    IOWS_ATT_W8_WORD = 2'h2,
    IOWS_ATT_W8_BYTE = 2'h3
  } iows_attach_e;
  localparam int IOWS_CNT_W = 4;
  localparam int IOWS_DATA_W = 32;
  localparam logic [IOWS_CNT_W-1:0] IOWS_CNT_ZERO = 4'h0;
  localparam logic [IOWS_CNT_W-1:0] IOWS_CNT_ONE = 4'h1;
  // Lane offsets within a word for word-aligned peripherals
  localparam logic [1:0] IOWS_OFS_NONE = 2'h0;
  localparam logic [1:0] IOWS_OFS_HALF = 2'h2;
  localparam logic [1:0] IOWS_OFS_BYTE = 2'h3;
  // Address step between consecutive peripheral registers
  localparam logic [2:0] IOWS_STEP_WORD = 3'h4;
  localparam logic [2:0] IOWS_STEP_HALF = 3'h2;
  localparam logic [2:0] IOWS_STEP_BYTE = 3'h1;
  // Reset value of the captured read data
  localparam logic [IOWS_DATA_W-1:0] IOWS_DATA_RST = 32'h0000_0000;
endpackage

// File: logic/iows_sequencer.sv
// Peripheral port wait-state sequencer: strobes, data-ready, alignment
`timescale 1ns/1ns
// Summary of operation
// - Start-repeat count delays chip select, one clock each
// - Start repeat applies to reads, writes, every style
// - Read: data-ready withheld for 0-15 read delay
// - Read data captured in the data-ready clock
// - Write: data-ready withheld for 0-15 write delay
// - External wait sampled a clock ahead, acts later
// - Wait during data-ready repeats sample, data-ready held
// - Word-aligned 16-bit: 0x02 offset per lane/endian
// - Word-aligned 8-bit: 0x03 offset for opposite lane
// - Base: select, strobe, strobe off, select off
// - Direction style: direction with select, single strobe
// - Card style: select pair follows valid byte lanes
module iows_sequencer (
  input wire logic clk,
  input wire logic rst,
  input wire logic accessStart,
  input wire logic accessWrite,
  input wire iows_pkg::iows_style_e portStyle,
  input wire logic [1:0] byteValid,
  input wire logic [iows_pkg::IOWS_CNT_W-1:0] startRepeatCount,
  input wire logic [iows_pkg::IOWS_CNT_W-1:0] readDataDelay,
  input wire logic [iows_pkg::IOWS_CNT_W-1:0] writeDataDelay,
  input wire iows_pkg::iows_attach_e attachMode,
  input wire logic upperLane,
  input wire logic bigEndian,
  input wire logic extWaitInput,
  input wire logic [iows_pkg::IOWS_DATA_W-1:0] systemDataBusIn,
  output logic accessBusy,
  output logic accessDone,
  output logic [1:0] periphSelectN,
  output logic periphReadStrobeN,
  output logic periphWriteStrobeN,
  output logic periphDataStrobeN,
  output logic periphDirectionLine,
  output logic dataReadyStrobeN,
  output logic [iows_pkg::IOWS_DATA_W-1:0] readData,
  output logic [1:0] laneOffset,
  output logic [2:0] registerStep
);
  import iows_pkg::*;

  typedef enum logic [2:0] {
    IDLE, START, SELECT, DATA, RELEASE, FINISH
  } iows_state_e;

  iows_state_e state_reg, state_next;
  logic [IOWS_CNT_W-1:0] cnt_reg, cnt_next;
  logic write_reg;
  iows_style_e style_reg;
  logic [1:0] lanes_reg;
  logic waitMeta_reg, waitSync_reg;
  logic [IOWS_DATA_W-1:0] readData_reg;
  logic [1:0] selN_reg;
  logic rdN_reg, wrN_reg, dsN_reg, dir_reg, drN_reg, done_reg;
  wire logic [IOWS_CNT_W-1:0] dataDelay;
  wire logic delayDone;
  wire logic readyNow;
  wire logic selOn, strobeOn, dirStyle, cardStyle;
  wire logic [1:0] selMask;

  // External wait passes two flip-flops; only the second is read
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      waitMeta_reg <= 1'b0;
      waitSync_reg <= 1'b0;
    end else begin
      waitMeta_reg <= extWaitInput;
      waitSync_reg <= waitMeta_reg;
    end
  end

  // Data delay chosen by direction of the access
  assign dataDelay = write_reg ? writeDataDelay : readDataDelay;
  assign delayDone = (cnt_reg == dataDelay);
  assign readyNow = (state_reg == DATA) && delayDone;

  // Sequence next state and wait-state counter
  always_comb begin
    state_next = state_reg;
    cnt_next = cnt_reg;
    case (state_reg)
      IDLE: begin
        if (accessStart) begin
          state_next = START;
          cnt_next = IOWS_CNT_ZERO;
        end
      end
      START: begin
        // Each repeat of the start cycle holds select off a clock
        if (waitSync_reg) begin
          state_next = START;
        end else if (cnt_reg == startRepeatCount) begin
          state_next = SELECT;
          cnt_next = IOWS_CNT_ZERO;
        end else begin
          cnt_next = cnt_reg + IOWS_CNT_ONE;
        end
      end
      SELECT: begin
        state_next = DATA;
      end
      DATA: begin
        if (!delayDone) begin
          cnt_next = cnt_reg + IOWS_CNT_ONE;
        end else if (waitSync_reg) begin
          state_next = DATA;
        end else begin
          state_next = RELEASE;
        end
      end
      RELEASE: begin
        state_next = FINISH;
      end
      FINISH: begin
        state_next = IDLE;
      end
      default: begin
        state_next = IDLE;
      end
    endcase
  end

  // Pin levels that follow from the next state
  assign dirStyle = (style_reg == IOWS_STYLE_DIR);
  assign cardStyle = (style_reg == IOWS_STYLE_CARD);
  assign selOn = (state_next == SELECT) || (state_next == DATA) ||
                 (state_next == RELEASE);
  assign strobeOn = (state_next == DATA);
  assign selMask = cardStyle ? lanes_reg : 2'h3;

  // Access state and captured attributes
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      state_reg <= IDLE;
      cnt_reg <= IOWS_CNT_ZERO;
      write_reg <= 1'b0;
      style_reg <= IOWS_STYLE_SPLIT;
      lanes_reg <= 2'h0;
    end else begin
      state_reg <= state_next;
      cnt_reg <= cnt_next;
      if (state_reg == IDLE && accessStart) begin
        write_reg <= accessWrite;
        style_reg <= portStyle;
        lanes_reg <= byteValid;
      end
    end
  end

  // Registered pin outputs, all active low except direction and done
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      selN_reg <= 2'h3;
      rdN_reg <= 1'b1;
      wrN_reg <= 1'b1;
      dsN_reg <= 1'b1;
      dir_reg <= 1'b0;
      drN_reg <= 1'b1;
      done_reg <= 1'b0;
    end else begin
      selN_reg <= ~(selOn ? selMask : 2'h0);
      rdN_reg <= ~(strobeOn && !dirStyle && !write_reg);
      wrN_reg <= ~(strobeOn && !dirStyle && write_reg);
      dsN_reg <= ~(strobeOn && dirStyle);
      dir_reg <= selOn && dirStyle && write_reg;
      drN_reg <= ~((state_next == DATA) && (cnt_next == dataDelay));
      done_reg <= (state_next == FINISH);
    end
  end

  // Read data sampled in the clock where data-ready is low
  always_ff @(posedge clk or posedge rst) begin
    if (rst) begin
      readData_reg <= IOWS_DATA_RST;
    end else if (readyNow && !write_reg) begin
      readData_reg <= systemDataBusIn;
    end
  end

  // Alignment helpers for software address generation
  always_comb begin
    laneOffset = IOWS_OFS_NONE;
    registerStep = IOWS_STEP_WORD;
    case (attachMode)
      IOWS_ATT_W16_WORD: begin
        laneOffset = (upperLane ^ bigEndian) ? IOWS_OFS_HALF
                                             : IOWS_OFS_NONE;
      end
      IOWS_ATT_W16_HALF: begin
        registerStep = IOWS_STEP_HALF;
      end
      IOWS_ATT_W8_WORD: begin
        laneOffset = (upperLane ^ bigEndian) ? IOWS_OFS_BYTE
                                             : IOWS_OFS_NONE;
      end
      default: begin
        registerStep = IOWS_STEP_BYTE;
      end
    endcase
  end

  assign accessBusy = (state_reg != IDLE);
  assign accessDone = done_reg;
  assign periphSelectN = selN_reg;
  assign periphReadStrobeN = rdN_reg;
  assign periphWriteStrobeN = wrN_reg;
  assign periphDataStrobeN = dsN_reg;
  assign periphDirectionLine = dir_reg;
  assign dataReadyStrobeN = drN_reg;
  assign readData = readData_reg;
endmodule // iows_sequencer

// File: tb/iows_sequencer_asserts.sv
// Checker for select, strobe and wait timing of the sequencer
`timescale 1ns/1ns
module iows_sequencer_asserts (
  input wire logic clk,
  input wire logic rst,
  input wire logic accessStart,
  input wire logic accessBusy,
  input wire logic [3:0] startRepeatCount,
  input wire logic extWaitInput,
  input wire logic accessDone,
  input wire logic [1:0] periphSelectN,
  input wire logic periphReadStrobeN,
  input wire logic periphWriteStrobeN,
  input wire logic periphDataStrobeN,
  input wire logic periphDirectionLine,
  input wire logic dataReadyStrobeN
);
  default clocking cb @(posedge clk); endclocking
  default disable iff (rst);
  // Request taken while idle
  sequence accepted; accessStart && !accessBusy; endsequence
  sel_delay_a: assert property ((accepted and startRepeatCount == 4'h1)
    |=> periphSelectN == 2'h3 [*2]) else $error("select early");
  busy_set_a: assert property (accepted |=> accessBusy [*2])
    else $error("busy missing");
  wait_hold_a: assert property ($past(extWaitInput, 2)
    && !dataReadyStrobeN |=> !dataReadyStrobeN) else $error("ready dropped");
  wait_end_a: assert property (!$past(extWaitInput, 2)
    && !dataReadyStrobeN |=> dataReadyStrobeN) else $error("ready held");
  drop_sel_a: assert property (accessDone |-> periphSelectN == 2'h3
    && $past(periphSelectN) != 2'h3) else $error("select not released");
  read_sel_a: assert property (!periphReadStrobeN
    |-> periphSelectN != 2'h3) else $error("read strobe outside select");
  data_sel_a: assert property (!periphDataStrobeN
    |-> periphSelectN != 2'h3) else $error("data strobe outside select");
  write_sel_a: assert property (!periphWriteStrobeN
    |-> periphSelectN != 2'h3) else $error("write strobe outside select");
  dir_sel_a: assert property (periphDirectionLine
    |-> periphSelectN == 2'h0) else $error("direction outside select");
  ready_end_a: assert property ($rose(dataReadyStrobeN)
    |-> periphReadStrobeN && periphDataStrobeN) else $error("strobe held");
endmodule // iows_sequencer_asserts
bind iows_sequencer iows_sequencer_asserts iows_sequencer_asserts_i (.*);

// File: tb/iows_periph_model.sv
// Far-side peripheral that answers reads
`timescale 1ns/1ns
module iows_periph_model (
  input wire logic [1:0] periphSelectN,
  input wire logic periphReadStrobeN,
  input wire logic periphDataStrobeN,
  input wire logic [31:0] rdValue,
  output logic [31:0] systemDataBusIn
);
  // Released bus shows the inverse so stale data never matches
  // Either select of the pair enables the shared transceivers
  assign systemDataBusIn = (periphSelectN != 2'h3 && !(periphReadStrobeN
    && periphDataStrobeN)) ? rdValue : ~rdValue;
endmodule // iows_periph_model

// File: tb/tb_iows_sequencer.sv
// Self-checking bench for the wait-state sequencer
`timescale 1ns/1ns
module tb_iows_sequencer;
  import iows_pkg::*;
  logic clk = 1'b0, rst = 1'b1, accessStart = 1'b0, accessWrite = 1'b0;
  logic upperLane = 1'b0, bigEndian = 1'b0, extWaitInput = 1'b0;
  iows_style_e portStyle = IOWS_STYLE_SPLIT;
  iows_attach_e attachMode = IOWS_ATT_W16_WORD;
  logic [3:0] startRepeatCount = 4'h0, readDataDelay = 4'h0;
  logic [3:0] writeDataDelay = 4'h0;
  logic [31:0] rdValue = 32'h0, systemDataBusIn, readData;
  logic accessBusy, accessDone, periphReadStrobeN, periphWriteStrobeN;
  logic periphDataStrobeN, periphDirectionLine, dataReadyStrobeN;
  logic [1:0] byteValid = 2'h3, periphSelectN, laneOffset;
  logic [2:0] registerStep;
  int errors = 0, num_checks = 0;
  iows_sequencer iows_sequencer_i (.*);
  iows_periph_model iows_periph_model_i (.*);
  // Clock of 50 ns period
  always #25 clk = ~clk;
  // Compare and count
  task automatic check(input string nm, input logic [31:0] got, exp);
    num_checks++;
    if (got !== exp) begin
      errors++;
      $display("Error %s exp %h got %h", nm, exp, got);
    end
  endtask
  // Verdict and end of run
  task automatic results;
    if (errors == 0 && num_checks > 0) $display("== PASSED ==");
    else $display("== FAILED ==");
    $finish;
  endtask
  // One access with an ignored second start; w places the wait pulse
  task automatic run(input logic wr, input iows_style_e st,
      input logic [1:0] bv, input logic [3:0] s, d, input int w,
      input logic [31:0] v);
    int n = 0, rs = 0, ws = 0, ds = 0, dr = 0, rdy = 0, ok = 0;
    int hold, stc;
    logic wPrev = 1'b0;
    logic dirSt;
    logic [1:0] sl = 2'h3;
    logic [1:0] selExp;
    // Wait pulse acting on the data-ready clock repeats that clock
    hold = (w == s + d + 1) ? 1 : 0;
    stc = d + 1 + hold;
    dirSt = (st == IOWS_STYLE_DIR);
    selExp = (st == IOWS_STYLE_CARD) ? ~bv : 2'h0;
    accessWrite = wr;
    portStyle = st;
    byteValid = bv;
    startRepeatCount = s;
    readDataDelay = wr ? d + 4'h3 : d;
    writeDataDelay = wr ? d : d + 4'h5;
    rdValue = v;
    accessStart = 1'b1;
    @(negedge clk);
    accessStart = 1'b0;
    while (accessDone !== 1'b1 && n < 40) begin
      if (!periphReadStrobeN) rs++;
      if (!periphWriteStrobeN) ws++;
      if (!periphDataStrobeN) ds++;
      if (periphDirectionLine) dr++;
      if (!dataReadyStrobeN) rdy++;
      if (!dataReadyStrobeN && !wPrev) ok++;
      if (periphSelectN != 2'h3) sl = periphSelectN;
      wPrev = extWaitInput;
      n++;
      accessStart = (n == 2);
      extWaitInput = (n == w);
      @(negedge clk);
    end
    check("length", n, 4 + s + d + (w > 0));
    check("read strobe", rs, (!wr && !dirSt) ? stc : 0);
    check("write strobe", ws, (wr && !dirSt) ? stc : 0);
    check("data strobe", ds, dirSt ? stc : 0);
    check("direction", dr, (wr && dirSt) ? stc + 2 : 0);
    check("ready", rdy, 1 + hold);
    check("valid samples", ok, 1);
    check("select", sl, selExp);
    if (!wr) check("data", readData, v);
    if (n == 40) results();
    @(negedge clk);
    check("busy", accessBusy, 1'b0);
  endtask
  initial begin
    repeat (5) @(posedge clk);
    @(negedge clk);
    rst = 1'b0;
    run(1'b0, IOWS_STYLE_SPLIT, 2'h3, 4'h0, 4'h0, 0, 32'hA5C30F19);
    run(1'b1, IOWS_STYLE_SPLIT, 2'h3, 4'h1, 4'h2, 0, 32'h0);
    run(1'b0, IOWS_STYLE_DIR, 2'h3, 4'h2, 4'hF, 0, 32'h12345678);
    run(1'b1, IOWS_STYLE_DIR, 2'h3, 4'h0, 4'h0, 0, 32'h0);
    run(1'b0, IOWS_STYLE_CARD, 2'h2, 4'h3, 4'h0, 0, 32'h00FFFF00);
    run(1'b0, IOWS_STYLE_SPLIT, 2'h3, 4'h0, 4'h1, 2, 32'h80017FFE);
    run(1'b1, IOWS_STYLE_CARD, 2'h1, 4'h3, 4'h0, 1, 32'h0);
    // Reset in mid-access returns pins and state to idle levels
    accessStart = 1'b1;
    @(negedge clk);
    accessStart = 1'b0;
    repeat (5) @(negedge clk);
    check("strobe on", periphWriteStrobeN, 1'b0);
    rst = 1'b1;
    @(negedge clk);
    check("reset select", periphSelectN, 2'h3);
    check("reset busy", accessBusy, 1'b0);
    check("reset data", readData, 32'h0);
    rst = 1'b0;
    // Lane offset and register step for each hookup
    for (int i = 0; i < 16; i++) begin
      {upperLane, bigEndian} = i[1:0];
      attachMode = iows_attach_e'(i[3:2]);
      @(negedge clk);
      check("ofs", laneOffset,
        (!i[2] && i[1] != i[0]) ? {1'b1, i[3]} : 2'h0);
      check("step", registerStep,
        i[2] ? (i[3] ? 3'h1 : 3'h2) : 3'h4);
    end
    results();
  end
endmodule // tb_iows_sequencer
